// file: dv/adc_two_wire_slave_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module adc_two_wire_slave_control_monitor
  import adc_ctl_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       convClk,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic [7:0] anaPos,
  input wire logic [7:0] anaNeg,
  input wire logic [3:0] chanSel,
  input wire logic [2:0] refSelect,
  input wire logic       extClkMode,
  input wire logic       hsModeOn
);
  localparam int STRETCH_LIM = int'(STRETCH_CYC) * RAM_DEPTH;
  logic      sclPrev_ff;
  logic      sdaPrev_ff;
  logic      busIdle_ff;
  int        stretchCnt_ff;
  wire logic startSeen = sclIn & sclPrev_ff & sdaPrev_ff & ~sdaIn;
  wire logic stopSeen  = sclIn & sclPrev_ff & ~sdaPrev_ff & sdaIn;

  // idle from stop to next start
  always_ff @(posedge clk_sys) begin
    sclPrev_ff    <= sclIn;
    sdaPrev_ff    <= sdaIn;
    busIdle_ff    <= sys_rst | stopSeen | (busIdle_ff & ~startSeen);
    stretchCnt_ff <= sclOe ? stretchCnt_ff + 1 : 0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_PIN_LOW: assert property (!sdaOut && !sclOut)
    else $error("pin drives high");
  AST_SDA_STILL: assert property (sclIn && sclPrev_ff |-> $stable(sdaOe))
    else $error("sda moved while scl high");
  AST_IDLE_QUIET: assert property (busIdle_ff |-> !sdaOe && !sclOe)
    else $error("drive while bus idle");
  AST_STRETCH_LOW: assert property ($rose(sclOe) |-> !sclPrev_ff)
    else $error("stretch began with scl high");
  AST_STRETCH_MAX: assert property (stretchCnt_ff <= STRETCH_LIM)
    else $error("stretch too long");
  AST_HS_NACK: assert property ($rose(hsModeOn) |-> !sdaOe && !sclPrev_ff)
    else $error("high speed entry without nack");
  AST_HS_KEEP: assert property (startSeen && hsModeOn |=> hsModeOn [*6])
    else $error("start dropped high speed");
  AST_HS_STOP: assert property (stopSeen |-> ##[1:8] !hsModeOn)
    else $error("stop kept high speed");
  AST_SETUP_WR: assert property ($changed(refSelect) || $changed(extClkMode)
    |-> !sclPrev_ff && !busIdle_ff)
    else $error("setup changed outside write");

  cover property ($rose(hsModeOn));
  cover property ($rose(sclOe));
  cover property ($rose(extClkMode));
endmodule // adc_two_wire_slave_control_monitor

bind adc_two_wire_slave_control adc_two_wire_slave_control_monitor chk (
  .clk_sys, .sys_rst, .convClk, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut, .sdaOe,
  .anaPos, .anaNeg, .chanSel, .refSelect, .extClkMode, .hsModeOn
);

`default_nettype wire

// file: dv/test_adc_two_wire_slave_control.sv
`timescale 1ns/10ps
`default_nettype none

module test_adc_two_wire_slave_control import adc_ctl_pkg::*;;
  logic       clk_sys;
  logic       sys_rst;
  logic       convClk;
  logic       mScl;
  logic       mSda;
  logic       sclOe;
  logic       sdaOe;
  logic       extClkMode;
  logic       hsModeOn;
  logic [2:0] refSelect;
  logic [3:0] chanSel;
  logic [7:0] anaPos = 8'h08;
  logic [7:0] anaNeg = 8'h18;
  wire logic  sclW = mScl & ~sclOe;
  wire logic  sdaW = mSda & ~sdaOe;
  int         errors;
  int         checks;

  initial begin
    clk_sys = 1'b0;
    convClk = 1'b0;
  end
  always #10 clk_sys = ~clk_sys;
  always #7.5 convClk = ~convClk;
  // channel n shows n*16+8 on the plus input
  always @(chanSel) #1 anaPos = {chanSel, 4'h8};

  adc_two_wire_slave_control uut (
    .clk_sys, .sys_rst, .convClk, .sclIn(sclW), .sclOut(), .sclOe, .sdaIn(sdaW),
    .sdaOut(), .sdaOe, .anaPos, .anaNeg, .chanSel, .refSelect, .extClkMode, .hsModeOn
  );
  two_wire_master_model m (.clk(clk_sys), .sclW, .sdaW, .mScl, .mSda);

  task automatic cmpBit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic cmpByte(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrCfg(input logic [7:0] a, input logic [7:0] b, input int n);
    logic k;
    m.start();
    m.wrByte({OWN_ADDR, 1'b0}, k);
    cmpBit("addrAck", 1'b1, k);
    m.wrByte(a, k);
    cmpBit("byteAck", 1'b1, k);
    if (n > 1) begin
      m.wrByte(b, k);
      cmpBit("byteAck", 1'b1, k);
    end
    m.stop();
  endtask

  task automatic readChk(input int n, input logic [31:0] e);
    logic       k;
    logic [7:0] b;
    m.start();
    m.wrByte({OWN_ADDR, 1'b1}, k);
    cmpBit("readAddrAck", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      m.rdByte(i < n - 1, b);
      cmpByte("result", e[31-8*i -: 8], b);
    end
    m.stop();
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys);
    errors++;
    test_done();
  end

  initial begin
    logic k;
    errors = 0;
    checks = 0;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    m.cyc(4);
    cmpByte("setupOut", 8'h00, {3'h0, refSelect, extClkMode, hsModeOn});
    readChk(2, 32'h0808_0000);
    $display("test defaults done");
    wrCfg(8'hc7, 8'h04, 2);
    cmpByte("refSelect", 8'h04, {5'h00, refSelect});
    readChk(4, 32'hf000_10f0);
    $display("test bipolar done");
    wrCfg(8'h04, 8'hc3, 2);
    readChk(3, 32'h0000_1000);
    $display("test unipolar done");
    wrCfg(8'hc6, 8'h05, 2);
    readChk(3, 32'h0818_2800);
    $display("test single ended done");
    wrCfg(8'hc5, 8'h00, 1);
    cmpByte("refSelect", 8'h04, {5'h00, refSelect});
    readChk(1, 32'h0800_0000);
    $display("test config reset done");
    wrCfg(8'hcb, 8'h03, 2);
    cmpBit("extClk", 1'b1, extClkMode);
    readChk(3, 32'h0818_0800);
    wrCfg(8'hc3, 8'h00, 1);
    cmpBit("extClk", 1'b0, extClkMode);
    $display("test external clock done");
    for (int i = 0; i < 2; i++) begin
      m.start();
      m.wrByte({OWN_ADDR ^ 7'h40, i[0]}, k);
      cmpBit("foreignAck", 1'b0, k);
      m.wrByte(8'h00, k);
      cmpBit("foreignByte", 1'b0, k);
      m.stop();
    end
    $display("test foreign address done");
    for (int i = 0; i < 8; i++) begin
      m.start();
      m.wrByte(8'h08 | 8'(i), k);
      cmpBit("codeAck", 1'b0, k);
      m.start();
      cmpBit("hsOn", 1'b1, hsModeOn);
      m.wrByte({OWN_ADDR, 1'b0}, k);
      cmpBit("hsAddrAck", 1'b1, k);
      m.stop();
      m.cyc(8);
      cmpBit("hsOff", 1'b0, hsModeOn);
    end
    $display("test high speed done");
    test_done();
  end
endmodule // test_adc_two_wire_slave_control

`default_nettype wire

// file: dv/two_wire_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module two_wire_master_model (
  input  wire logic clk,
  input  wire logic sclW,
  input  wire logic sdaW,
  output logic      mScl,
  output logic      mSda
);
  localparam int HALF = 10;

  initial begin
    mScl = 1'b1;
    mSda = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // release scl, then wait out stretching
  task automatic sclHigh();
    int n;
    mScl = 1'b1;
    n = 0;
    while (sclW !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    cyc(HALF);
  endtask

  task automatic start();
    mSda = 1'b1;
    cyc(HALF);
    sclHigh();
    mSda = 1'b0;
    cyc(HALF);
    mScl = 1'b0;
    cyc(3);
  endtask

  task automatic stop();
    mSda = 1'b0;
    cyc(HALF);
    sclHigh();
    mSda = 1'b1;
    cyc(HALF);
  endtask

  task automatic xbit(input logic b, output logic r);
    mSda = b;
    cyc(HALF);
    sclHigh();
    r = sdaW;
    mScl = 1'b0;
    cyc(3);
  endtask

  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = (r === 1'b0);
  endtask

  task automatic rdByte(input logic mAck, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(!mAck, r);
  endtask
endmodule // two_wire_master_model

`default_nettype wire

// file: hdl/adc_ctl_pkg.sv
package adc_ctl_pkg;

  // own bus address; value is arbitrary
  localparam logic [6:0] OWN_ADDR       = 7'h2a;
  // high-speed master code: top five bits 0000 1
  localparam logic [4:0] MASTER_CODE_HI = 5'h01;

  // shared field: byte kind
  localparam int REG_BIT  = 7;
  // setup byte fields
  localparam int SEL_MSB  = 6;
  localparam int SEL_LSB  = 4;
  localparam int CLK_BIT  = 3;
  localparam int BIP_BIT  = 2;
  localparam int RST_BIT  = 1;
  localparam int DC_BIT   = 0;
  // configuration byte fields
  localparam int SCAN_MSB = 6;
  localparam int SCAN_LSB = 5;
  localparam int CS_MSB   = 4;
  localparam int CS_LSB   = 1;
  localparam int SGL_BIT  = 0;

  localparam logic [7:0] SETUP_RESET  = 8'h80;
  localparam logic [7:0] CONFIG_RESET = 8'h01;

  localparam int         RAM_DEPTH = 12;
  localparam logic [3:0] MAX_CHAN  = 4'hb;

  // conversion: acquire cycles then one cycle per bit
  localparam int         CONV_ACQ_CYC  = 2;
  localparam int         CONV_BIT_CYC  = 8;
  localparam logic [3:0] CONV_LAST_PH  = 4'(CONV_ACQ_CYC + CONV_BIT_CYC - 1);

  // longest clock stretch per channel, rounded down
  localparam int          STRETCH_NS   = 7600;
  localparam int          CLK_SYS_NS   = 20;
  localparam logic [12:0] STRETCH_CYC  = 13'(STRETCH_NS / CLK_SYS_NS);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_MC_NACK, ST_WR_BYTE, ST_WR_ACK,
    ST_CONV_WAIT, ST_LOAD, ST_RD_BYTE, ST_RD_ACK, ST_IGNORE
  } bus_state_t;

  typedef struct packed {
    logic       single;
    logic       bipolar;
    logic [3:0] first;
    logic [3:0] count;
  } conv_cfg_t;

  typedef struct packed {
    bus_state_t  st;
    logic [3:0]  bitCnt;
    logic [7:0]  shReg;
    logic [7:0]  setupReg;
    logic [7:0]  cfgReg;
    logic        hsMode;
    logic        readDir;
    logic [3:0]  rdPtr;
    logic        reqTgl;
    logic        mAck;
    logic [12:0] stretchCnt;
    logic        sdaLow;
    logic        sclLow;
    logic [1:0]  sclSync;
    logic [1:0]  sdaSync;
    logic [1:0]  doneSync;
    logic        sclPrev;
    logic        sdaPrev;
    logic        donePrev;
  } slave_state_t;

  typedef struct packed {
    logic [1:0] rstSync;
    logic [1:0] reqSync;
    logic       reqPrev;
    logic       busy;
    conv_cfg_t  cfg;
    logic [3:0] phase;
    logic [3:0] idx;
    logic [3:0] chan;
    logic       doneTgl;
    logic [7:0] posMeta;
    logic [7:0] posSync;
    logic [7:0] negMeta;
    logic [7:0] negSync;
  } conv_state_t;

endpackage

// file: hdl/adc_two_wire_slave_control.sv
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - byte MSB one is setup, else configuration
// - polarity bit: one bipolar, zero unipolar
// - reset bit zero restores configuration defaults
// - setup byte LSB is ignored
// - single-ended converts channel against ground
// - pseudo-differential converts selected pair difference
// - unipolar negative difference gives zero code
// - unipolar straight binary, bipolar two's complement
// - single-ended always converts unipolar
// - nine clocks per byte: eight data, ack
// - SDA change while SCL high is control
// - repeated start keeps bus and timing mode
// - ack drives SDA low through ninth clock
// - idle watches start plus own address
// - address LSB: zero write, one read
// - matching address acknowledged for one clock
// - stop returns timing to fast/standard
// - write accepts control bytes, each acknowledged
// - read continues on ack, releases on nack
// - internal clock stretches SCL, bounded per channel
// - results read in order, pointer wraps
// - external clock converts per byte until nack
module adc_two_wire_slave_control
  import adc_ctl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       convClk,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic [7:0] anaPos,
  input  wire logic [7:0] anaNeg,
  output logic      [3:0] chanSel,
  output logic      [2:0] refSelect,
  output logic            extClkMode,
  output logic            hsModeOn
);

  slave_state_t q;
  slave_state_t n;
  conv_cfg_t    convCfg;
  logic         scl;
  logic         sda;
  logic         sclRise;
  logic         sclFall;
  logic         startEv;
  logic         stopEv;
  logic         doneEv;
  logic         extMode;
  logic [3:0]   csSel;
  logic [3:0]   nRes;
  logic [3:0]   scanFirst;
  logic [3:0]   rdIdx;
  logic [7:0]   rdData;
  logic         doneTgl;
  logic [12:0]  stretchLim;

  // scan: mode 00 walks channels 0..cs, others repeat cs
  always_comb begin
    csSel     = (q.cfgReg[CS_MSB:CS_LSB] > MAX_CHAN) ? MAX_CHAN : q.cfgReg[CS_MSB:CS_LSB];
    extMode   = q.setupReg[CLK_BIT];
    if (q.cfgReg[SCAN_MSB:SCAN_LSB] == 2'b00) begin
      scanFirst = 4'h0;
      nRes      = csSel + 4'h1;
    end else begin
      scanFirst = csSel;
      nRes      = 4'h1;
    end
    convCfg.single  = q.cfgReg[SGL_BIT];
    convCfg.bipolar = q.setupReg[BIP_BIT];
    if (extMode) begin
      convCfg.first = scanFirst + q.rdPtr;
      convCfg.count = 4'h1;
      rdIdx         = 4'h0;
    end else begin
      convCfg.first = scanFirst;
      convCfg.count = nRes;
      rdIdx         = q.rdPtr;
    end
    stretchLim = STRETCH_CYC * 13'(convCfg.count);
  end

  always_comb begin
    n          = q;
    n.sclSync  = {q.sclSync[0], sclIn};
    n.sdaSync  = {q.sdaSync[0], sdaIn};
    n.doneSync = {q.doneSync[0], doneTgl};
    scl        = q.sclSync[1];
    sda        = q.sdaSync[1];
    n.sclPrev  = scl;
    n.sdaPrev  = sda;
    n.donePrev = q.doneSync[1];
    sclRise    = scl && !q.sclPrev;
    sclFall    = !scl && q.sclPrev;
    doneEv     = q.doneSync[1] != q.donePrev;
    startEv    = scl && q.sclPrev && q.sdaPrev && !sda;
    stopEv     = scl && q.sclPrev && !q.sdaPrev && sda;
    case (q.st)
      ST_ADDR: begin
        if (sclRise) begin
          n.shReg  = {q.shReg[6:0], sda};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'h8) begin
          n.bitCnt = 4'h0;
          if (q.shReg[7:3] == MASTER_CODE_HI) begin
            n.st = ST_MC_NACK;
          end else if (q.shReg[7:1] == OWN_ADDR) begin
            n.sdaLow  = 1'b1;
            n.readDir = q.shReg[0];
            n.st      = ST_ADDR_ACK;
          end else begin
            n.st = ST_IGNORE;
          end
        end
      end
      ST_MC_NACK: begin
        if (sclFall) begin
          n.hsMode = 1'b1;
          n.st     = ST_IGNORE;
        end
      end
      ST_ADDR_ACK: begin
        if (sclFall) begin
          n.sdaLow = 1'b0;
          if (q.readDir) begin
            n.rdPtr      = 4'h0;
            n.reqTgl     = ~q.reqTgl;
            n.stretchCnt = 13'h0;
            n.sclLow     = 1'b1;
            n.st         = ST_CONV_WAIT;
          end else begin
            n.st = ST_WR_BYTE;
          end
        end
      end
      ST_WR_BYTE: begin
        if (sclRise) begin
          n.shReg  = {q.shReg[6:0], sda};
          n.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'h8) begin
          n.bitCnt = 4'h0;
          n.sdaLow = 1'b1;
          n.st     = ST_WR_ACK;
          if (q.shReg[REG_BIT]) begin
            n.setupReg         = q.shReg;
            n.setupReg[DC_BIT] = 1'b0;
            if (!q.shReg[RST_BIT]) begin
              n.cfgReg = CONFIG_RESET;
            end
          end else begin
            n.cfgReg = q.shReg;
          end
        end
      end
      ST_WR_ACK: begin
        if (sclFall) begin
          n.sdaLow = 1'b0;
          n.st     = ST_WR_BYTE;
        end
      end
      ST_CONV_WAIT: begin
        n.stretchCnt = q.stretchCnt + 13'h1;
        if (doneEv) begin
          n.st = ST_LOAD;
        end else if (q.stretchCnt >= stretchLim) begin
          n.sclLow = 1'b0;
          n.st     = ST_IGNORE;
        end
      end
      ST_LOAD: begin
        n.shReg  = rdData;
        n.sdaLow = !rdData[7];
        n.bitCnt = 4'h0;
        n.st     = ST_RD_BYTE;
      end
      ST_RD_BYTE: begin
        // release stretch one cycle after first data bit settles
        n.sclLow = 1'b0;
        if (sclFall) begin
          if (q.bitCnt == 4'h7) begin
            n.sdaLow = 1'b0;
            n.st     = ST_RD_ACK;
          end else begin
            n.bitCnt = q.bitCnt + 4'h1;
            n.shReg  = {q.shReg[6:0], 1'b0};
            n.sdaLow = !q.shReg[6];
          end
        end
      end
      ST_RD_ACK: begin
        if (sclRise) begin
          n.mAck = !sda;
        end else if (sclFall) begin
          if (!q.mAck) begin
            n.st = ST_IGNORE;
          end else if (extMode) begin
            n.rdPtr      = (q.rdPtr + 4'h1 == nRes) ? 4'h0 : q.rdPtr + 4'h1;
            n.reqTgl     = ~q.reqTgl;
            n.stretchCnt = 13'h0;
            n.sclLow     = 1'b1;
            n.st         = ST_CONV_WAIT;
          end else begin
            n.rdPtr = (q.rdPtr + 4'h1 == nRes) ? 4'h0 : q.rdPtr + 4'h1;
            n.st    = ST_LOAD;
          end
        end
      end
      default: begin
      end
    endcase
    if (stopEv) begin
      n.st     = ST_IDLE;
      n.hsMode = 1'b0;
      n.sdaLow = 1'b0;
      n.sclLow = 1'b0;
    end else if (startEv) begin
      n.st     = ST_ADDR;
      n.bitCnt = 4'h0;
      n.sdaLow = 1'b0;
      n.sclLow = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q          <= '0;
      q.st       <= ST_IDLE;
      q.setupReg <= SETUP_RESET;
      q.cfgReg   <= CONFIG_RESET;
      q.sclSync  <= 2'b11;
      q.sdaSync  <= 2'b11;
      q.sclPrev  <= 1'b1;
      q.sdaPrev  <= 1'b1;
    end else begin
      q <= n;
    end
  end

  conv_result_engine u_conv (
    .convClk (convClk),
    .sys_rst (sys_rst),
    .reqTgl  (q.reqTgl),
    .convCfg (convCfg),
    .anaPos  (anaPos),
    .anaNeg  (anaNeg),
    .rdIdx   (rdIdx),
    .chanSel (chanSel),
    .doneTgl (doneTgl),
    .rdData  (rdData)
  );

  // open drain: only ever pull low
  assign sclOut     = 1'b0;
  assign sclOe      = q.sclLow;
  assign sdaOut     = 1'b0;
  assign sdaOe      = q.sdaLow;
  assign refSelect  = q.setupReg[SEL_MSB:SEL_LSB];
  assign extClkMode = q.setupReg[CLK_BIT];
  assign hsModeOn   = q.hsMode;

endmodule // adc_two_wire_slave_control

`default_nettype wire

// file: hdl/conv_result_engine.sv
`timescale 1ns/10ps
`default_nettype none

module conv_result_engine
  import adc_ctl_pkg::*;
(
  input  wire logic       convClk,
  input  wire logic       sys_rst,
  input  wire logic       reqTgl,
  input  wire conv_cfg_t  convCfg,
  input  wire logic [7:0] anaPos,
  input  wire logic [7:0] anaNeg,
  input  wire logic [3:0] rdIdx,
  output logic      [3:0] chanSel,
  output logic            doneTgl,
  output logic      [7:0] rdData
);

  conv_state_t q;
  conv_state_t n;
  logic [7:0]  ram [RAM_DEPTH];
  logic [8:0]  diff;
  logic [7:0]  code;
  logic        wrEn;

  always_comb begin
    n          = q;
    wrEn       = 1'b0;
    n.rstSync  = {q.rstSync[0], sys_rst};
    n.reqSync  = {q.reqSync[0], reqTgl};
    n.reqPrev  = q.reqSync[1];
    n.posMeta  = anaPos;
    n.posSync  = q.posMeta;
    n.negMeta  = anaNeg;
    n.negSync  = q.negMeta;
    diff       = {1'b0, q.posSync} - {1'b0, q.negSync};
    if (q.cfg.single) begin
      code = q.posSync;
    end else if (!q.cfg.bipolar) begin
      code = diff[8] ? 8'h00 : diff[7:0];
    end else if (!diff[8] && diff[7]) begin
      code = 8'h7f;
    end else if (diff[8] && !diff[7]) begin
      code = 8'h80;
    end else begin
      code = diff[7:0];
    end
    if (q.reqSync[1] != q.reqPrev) begin
      // settings are held steady by the requester until done
      n.busy  = 1'b1;
      n.cfg   = convCfg;
      n.phase = 4'h0;
      n.idx   = 4'h0;
      n.chan  = convCfg.first;
    end else if (q.busy) begin
      if (q.phase == CONV_LAST_PH) begin
        wrEn    = 1'b1;
        n.phase = 4'h0;
        n.idx   = q.idx + 4'h1;
        n.chan  = q.chan + 4'h1;
        if (q.idx + 4'h1 == q.cfg.count) begin
          n.busy    = 1'b0;
          n.doneTgl = ~q.doneTgl;
        end
      end else begin
        n.phase = q.phase + 4'h1;
      end
    end
    if (q.rstSync[1]) begin
      n         = '0;
      n.rstSync = {q.rstSync[0], sys_rst};
    end
  end

  always_ff @(posedge convClk) begin
    q <= n;
  end

  always_ff @(posedge convClk) begin
    if (wrEn) begin
      ram[q.idx] <= code;
    end
  end

  assign chanSel = q.chan;
  assign doneTgl = q.doneTgl;
  assign rdData  = (rdIdx < 4'(RAM_DEPTH)) ? ram[rdIdx] : 8'h00;

endmodule // conv_result_engine

`default_nettype wire
